// [bsx_map.vh]
`ifndef BSX_MAP_VH
`define BSX_MAP_VH

// Operation codes presented by the instruction decoder on op_code.
`define BSX_OP_W 4
`define BSX_OP_IO_SET 4'h0
`define BSX_OP_IO_CLR 4'h1
`define BSX_OP_LSL 4'h2
`define BSX_OP_LSR 4'h3
`define BSX_OP_ROL 4'h4
`define BSX_OP_ROR 4'h5
`define BSX_OP_ASR 4'h6
`define BSX_OP_SWAP 4'h7
`define BSX_OP_FSET 4'h8
`define BSX_OP_FCLR 4'h9
`define BSX_OP_BST 4'hA
`define BSX_OP_BLD 4'hB
`define BSX_OP_SEC 4'hC
`define BSX_OP_CLC 4'hD

// Bit positions inside the status register.
`define BSX_SR_C 0
`define BSX_SR_Z 1
`define BSX_SR_N 2
`define BSX_SR_V 3
`define BSX_SR_S 4
`define BSX_SR_H 5
`define BSX_SR_T 6
`define BSX_SR_I 7

// Reset values.
`define BSX_SR_RST 8'h00
`define BSX_BYTE_RST 8'h00
`define BSX_IO_ADDR_RST 6'h00
`define BSX_IDX_RST 5'h00

// Sequencer states of the I/O read-modify-write.
`define BSX_ST_IDLE 1'b0
`define BSX_ST_IO_RD 1'b1

`endif

// [bsx_bit_insert.v]
`timescale 1ns/100ps
`default_nettype none

// Replaces one selected bit of a byte with a new value, all other bits pass unchanged.
module bsx_bit_insert (
    input wire [7:0] data_in,
    input wire [2:0] bit_sel,
    input wire bit_val,
    output wire [7:0] data_out
);

    genvar i;

    // One multiplexer per bit; only the selected position takes the new value.
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            // A sized copy of the loop index keeps the compare at three bits.
            localparam [2:0] POS = i;
            assign data_out[i] = (bit_sel == POS) ? bit_val : data_in[i];
        end
    endgenerate

endmodule

`default_nettype wire

// [bsx_shifter.v]
`timescale 1ns/100ps
`default_nettype none
`include "bsx_map.vh"

// Combinational shift, rotate and nibble-swap network with the bit shifted out.
module bsx_shifter (
    input wire [3:0] op_code,
    input wire [7:0] operand,
    input wire carry_in,
    output reg [7:0] result,
    output reg carry_out
);

    // Carry keeps its old value for operations that shift nothing out.
    always @* begin
        result = operand;
        carry_out = carry_in;
        case (op_code)
            `BSX_OP_LSL: begin
                result = {operand[6:0], 1'b0};
                carry_out = operand[7];
            end
            `BSX_OP_LSR: begin
                result = {1'b0, operand[7:1]};
                carry_out = operand[0];
            end
            `BSX_OP_ROL: begin
                result = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            `BSX_OP_ROR: begin
                result = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            `BSX_OP_ASR: begin
                result = {operand[7], operand[7:1]};
                carry_out = operand[0];
            end
            `BSX_OP_SWAP: begin
                result = {operand[3:0], operand[7:4]};
            end
            default: begin
                result = operand;
            end
        endcase
    end

endmodule

`default_nettype wire

// [bsx_exec_unit.v]
// How it works
// - Setting an I/O bit forces bit b of I/O register P to one, others kept.
// - Clearing an I/O bit forces bit b of I/O register P to zero, others kept.
// - Logical left shift moves bits up one place and loads zero at bit zero.
// - Logical right shift moves bits down one place and loads zero at bit seven.
// - Rotate left puts old carry in bit zero and old bit seven in carry.
// - Rotate right puts old carry in bit seven and old bit zero in carry.
// - Arithmetic right shift moves bits down while bit seven keeps the sign.
// - Nibble swap exchanges the upper and lower four bits in one operation.
// - Flag set and clear force the status bit chosen by index s to one or zero.
// - Bit store copies bit b of the source into the transfer flag, source untouched.
// - Bit load copies the transfer flag into bit b of the destination only.
// - Set carry forces carry to one; clear carry forces it to zero.
`timescale 1ns/100ps
`default_nettype none
`include "bsx_map.vh"

module bsx_exec_unit (
    input wire core_clk,
    input wire sys_rst,
    input wire op_valid,
    input wire [3:0] op_code,
    input wire [4:0] rd_idx,
    input wire [7:0] rd_data,
    input wire [7:0] rr_data,
    input wire [2:0] bit_sel,
    input wire [2:0] flag_sel,
    input wire [5:0] io_addr,
    input wire [7:0] io_rdata,
    output reg busy_q,
    output reg done_q,
    output reg rd_wr_en_q,
    output reg [4:0] rd_idx_q,
    output reg [7:0] rd_wdata_q,
    output reg [7:0] status_q,
    output reg io_rd_en_q,
    output reg io_wr_en_q,
    output reg [5:0] io_addr_q,
    output reg [7:0] io_wdata_q
);

    reg state_q;
    reg state_d;
    reg [2:0] io_bit_q;
    reg [2:0] io_bit_d;
    reg io_set_q;
    reg io_set_d;
    reg busy_d;
    reg done_d;
    reg rd_wr_en_d;
    reg [4:0] rd_idx_d;
    reg [7:0] rd_wdata_d;
    reg [7:0] status_d;
    reg io_rd_en_d;
    reg io_wr_en_d;
    reg [5:0] io_addr_d;
    reg [7:0] io_wdata_d;
    reg sh_n;
    reg sh_v;

    wire accept;
    wire [7:0] sh_result;
    wire sh_carry;
    wire [7:0] io_modified;
    wire [7:0] bld_result;
    wire [7:0] flag_result;

    // New work is only taken while no I/O read-modify-write is in flight.
    assign accept = op_valid && (state_q == `BSX_ST_IDLE);

    bsx_shifter u_shifter (
        .op_code(op_code),
        .operand(rd_data),
        .carry_in(status_q[`BSX_SR_C]),
        .result(sh_result),
        .carry_out(sh_carry)
    );

    // The byte read back from the I/O space gets the captured bit forced.
    bsx_bit_insert u_io_bit (
        .data_in(io_rdata),
        .bit_sel(io_bit_q),
        .bit_val(io_set_q),
        .data_out(io_modified)
    );

    // Destination byte with the transfer flag dropped into bit b.
    bsx_bit_insert u_bld_bit (
        .data_in(rd_data),
        .bit_sel(bit_sel),
        .bit_val(status_q[`BSX_SR_T]),
        .data_out(bld_result)
    );

    // Status register with the bit chosen by the flag index forced.
    bsx_bit_insert u_flag_bit (
        .data_in(status_q),
        .bit_sel(flag_sel),
        .bit_val(op_code == `BSX_OP_FSET),
        .data_out(flag_result)
    );

    // Next-state logic; all strobes default low so each is a one-cycle pulse.
    always @* begin
        state_d = state_q;
        io_bit_d = io_bit_q;
        io_set_d = io_set_q;
        busy_d = busy_q;
        done_d = 1'b0;
        rd_wr_en_d = 1'b0;
        rd_idx_d = rd_idx_q;
        rd_wdata_d = rd_wdata_q;
        status_d = status_q;
        io_rd_en_d = 1'b0;
        io_wr_en_d = 1'b0;
        io_addr_d = io_addr_q;
        io_wdata_d = io_wdata_q;
        sh_n = sh_result[7];
        sh_v = sh_result[7] ^ sh_carry;
        case (state_q)
            `BSX_ST_IDLE: begin
                if (accept) begin
                    case (op_code)
                        `BSX_OP_IO_SET, `BSX_OP_IO_CLR: begin
                            // The read is issued now; the write follows next cycle.
                            state_d = `BSX_ST_IO_RD;
                            busy_d = 1'b1;
                            io_rd_en_d = 1'b1;
                            io_addr_d = io_addr;
                            io_bit_d = bit_sel;
                            io_set_d = (op_code == `BSX_OP_IO_SET);
                        end
                        `BSX_OP_LSL, `BSX_OP_LSR, `BSX_OP_ROL, `BSX_OP_ROR, `BSX_OP_ASR: begin
                            rd_wr_en_d = 1'b1;
                            rd_idx_d = rd_idx;
                            rd_wdata_d = sh_result;
                            done_d = 1'b1;
                            status_d[`BSX_SR_C] = sh_carry;
                            status_d[`BSX_SR_Z] = (sh_result == `BSX_BYTE_RST);
                            status_d[`BSX_SR_N] = sh_n;
                            status_d[`BSX_SR_V] = sh_v;
                            status_d[`BSX_SR_S] = sh_n ^ sh_v;
                        end
                        `BSX_OP_SWAP: begin
                            // Swap leaves every flag alone.
                            rd_wr_en_d = 1'b1;
                            rd_idx_d = rd_idx;
                            rd_wdata_d = sh_result;
                            done_d = 1'b1;
                        end
                        `BSX_OP_FSET, `BSX_OP_FCLR: begin
                            status_d = flag_result;
                            done_d = 1'b1;
                        end
                        `BSX_OP_BST: begin
                            // Nothing is written back, so the source stays as it was.
                            status_d[`BSX_SR_T] = rr_data[bit_sel];
                            done_d = 1'b1;
                        end
                        `BSX_OP_BLD: begin
                            rd_wr_en_d = 1'b1;
                            rd_idx_d = rd_idx;
                            rd_wdata_d = bld_result;
                            done_d = 1'b1;
                        end
                        `BSX_OP_SEC: begin
                            status_d[`BSX_SR_C] = 1'b1;
                            done_d = 1'b1;
                        end
                        `BSX_OP_CLC: begin
                            status_d[`BSX_SR_C] = 1'b0;
                            done_d = 1'b1;
                        end
                        default: begin
                            // Unused codes complete with no effect so the decoder never hangs.
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            `BSX_ST_IO_RD: begin
                // The I/O space answers the read in the same cycle, so the modified
                // byte is written back on the second edge without another wait.
                io_wr_en_d = 1'b1;
                io_wdata_d = io_modified;
                done_d = 1'b1;
                busy_d = 1'b0;
                state_d = `BSX_ST_IDLE;
            end
            default: begin
                state_d = `BSX_ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    // All state and every output are registered; reset loads constants only.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= `BSX_ST_IDLE;
            io_bit_q <= 3'h0;
            io_set_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rd_wr_en_q <= 1'b0;
            rd_idx_q <= `BSX_IDX_RST;
            rd_wdata_q <= `BSX_BYTE_RST;
            status_q <= `BSX_SR_RST;
            io_rd_en_q <= 1'b0;
            io_wr_en_q <= 1'b0;
            io_addr_q <= `BSX_IO_ADDR_RST;
            io_wdata_q <= `BSX_BYTE_RST;
        end else begin
            state_q <= state_d;
            io_bit_q <= io_bit_d;
            io_set_q <= io_set_d;
            busy_q <= busy_d;
            done_q <= done_d;
            rd_wr_en_q <= rd_wr_en_d;
            rd_idx_q <= rd_idx_d;
            rd_wdata_q <= rd_wdata_d;
            status_q <= status_d;
            io_rd_en_q <= io_rd_en_d;
            io_wr_en_q <= io_wr_en_d;
            io_addr_q <= io_addr_d;
            io_wdata_q <= io_wdata_d;
        end
    end

endmodule

`default_nettype wire

// [bsx_exec_checker.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bsx_map.vh"

// Ties each accepted request to the result seen one or two edges later.
module bsx_exec_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [4:0] rd_idx,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] rr_data,
    input wire logic [2:0] bit_sel,
    input wire logic [2:0] flag_sel,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_rdata,
    input wire logic busy_q,
    input wire logic done_q,
    input wire logic rd_wr_en_q,
    input wire logic [4:0] rd_idx_q,
    input wire logic [7:0] rd_wdata_q,
    input wire logic [7:0] status_q,
    input wire logic io_rd_en_q,
    input wire logic io_wr_en_q,
    input wire logic [5:0] io_addr_q,
    input wire logic [7:0] io_wdata_q
);
    // A request counts only while no read-modify-write is in flight.
    wire logic go;
    assign go = op_valid && !busy_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    property p_one; go && op_code > `BSX_OP_IO_CLR |=> done_q && !busy_q; endproperty
    a_one: assert property (p_one) else $error("one-cycle op not done");
    property p_set; go && op_code == `BSX_OP_IO_SET |=> io_rd_en_q ##1
        done_q && io_wdata_q == ($past(io_rdata) | 8'h01 << $past(bit_sel, 2)); endproperty
    a_set: assert property (p_set) else $error("io bit set wrong");
    property p_clr; go && op_code == `BSX_OP_IO_CLR |=> io_rd_en_q ##1
        done_q && io_wdata_q == ($past(io_rdata) & ~(8'h01 << $past(bit_sel, 2))); endproperty
    a_clr: assert property (p_clr) else $error("io bit clear wrong");
    property p_lsl; go && op_code == `BSX_OP_LSL |=>
        rd_wdata_q == {$past(rd_data[6:0]), 1'b0} && status_q[0] == $past(rd_data[7]); endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    property p_ror; go && op_code == `BSX_OP_ROR |=>
        rd_wdata_q == {$past(status_q[0]), $past(rd_data[7:1])}; endproperty
    a_ror: assert property (p_ror) else $error("right rotate wrong");
    property p_asr; go && op_code == `BSX_OP_ASR |=>
        rd_wdata_q == {$past(rd_data[7]), $past(rd_data[7:1])}; endproperty
    a_asr: assert property (p_asr) else $error("arithmetic shift wrong");
    property p_swp; go && op_code == `BSX_OP_SWAP |=>
        rd_wdata_q == {$past(rd_data[3:0]), $past(rd_data[7:4])} && $stable(status_q); endproperty
    a_swp: assert property (p_swp) else $error("swap wrong");
    property p_bst; go && op_code == `BSX_OP_BST |=> status_q[6] == $past(rr_data[bit_sel]); endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");
    c_io: cover property (go && op_code == `BSX_OP_IO_CLR);
    c_rol: cover property (go && op_code == `BSX_OP_ROL);
    c_bld: cover property (go && op_code == `BSX_OP_BLD);
endmodule

bind bsx_exec_unit bsx_exec_checker i_bsx_exec_checker (.*);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bsx_map.vh"

module testbench;
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg op_valid = 1'b0;
    reg [3:0] op_code = 4'h0;
    reg [4:0] rd_idx = 5'h00;
    reg [7:0] rd_data = 8'h00, rr_data = 8'h00, io_rdata = 8'h00, es = 8'h00;
    reg [2:0] bit_sel = 3'h0, flag_sel = 3'h0;
    reg [5:0] io_addr = 6'h00;
    reg [31:0] seed = 32'h3B08F201;
    wire busy_q, done_q, rd_wr_en_q, io_rd_en_q, io_wr_en_q;
    wire [4:0] rd_idx_q;
    wire [7:0] rd_wdata_q, status_q, io_wdata_q;
    wire [5:0] io_addr_q;
    integer num_errors = 0, check_count = 0, cycles = 0, k;

    bsx_exec_unit i_bsx_exec_unit (.core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .rd_idx(rd_idx), .rd_data(rd_data), .rr_data(rr_data), .bit_sel(bit_sel),
        .flag_sel(flag_sel), .io_addr(io_addr), .io_rdata(io_rdata), .busy_q(busy_q), .done_q(done_q),
        .rd_wr_en_q(rd_wr_en_q), .rd_idx_q(rd_idx_q), .rd_wdata_q(rd_wdata_q), .status_q(status_q),
        .io_rd_en_q(io_rd_en_q), .io_wr_en_q(io_wr_en_q), .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q));

    // Free-running core clock, 5 ns period.
    always #2.5 core_clk = ~core_clk;

    // A hang counts as a mismatch; the run needs well under this many cycles.
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            num_errors = num_errors + 1;
            results;
        end
    end

    function [31:0] xs(input [31:0] v);
        begin
            v = v ^ (v << 13);
            v = v ^ (v >> 17);
            xs = v ^ (v << 5);
        end
    endfunction

    // Returns the expected status in the upper byte and the result byte below it.
    function [15:0] expect_of(input [3:0] c, input [7:0] d, input [7:0] r, input [2:0] b,
        input [2:0] s, input [7:0] f);
        reg [7:0] er;
        reg cy;
        begin
            er = d;
            cy = f[0];
            case (c)
                `BSX_OP_LSL: {cy, er} = {d, 1'b0};
                `BSX_OP_LSR: {er, cy} = {1'b0, d};
                `BSX_OP_ROL: {cy, er} = {d, f[0]};
                `BSX_OP_ROR: {er, cy} = {f[0], d};
                `BSX_OP_ASR: {er, cy} = {d[7], d};
                `BSX_OP_SWAP: er = {d[3:0], d[7:4]};
                `BSX_OP_FSET: f[s] = 1'b1;
                `BSX_OP_FCLR: f[s] = 1'b0;
                `BSX_OP_BST: f[6] = r[b];
                `BSX_OP_BLD: er[b] = f[6];
                `BSX_OP_SEC: f[0] = 1'b1;
                `BSX_OP_CLC: f[0] = 1'b0;
                default: er = d;
            endcase
            // Only shifts and rotates rewrite C, Z, N, V and S together.
            if (c >= `BSX_OP_LSL && c <= `BSX_OP_ASR) begin
                f[3:0] = {er[7] ^ cy, er[7], er == 8'h00, cy};
                f[4] = f[2] ^ f[3];
            end
            expect_of = {f, er};
        end
    endfunction

    task chk(input [7:0] seen, input [7:0] want);
        begin
            check_count = check_count + 1;
            if (seen !== want) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask

    // Issues one request at the current edge and checks its outcome once it completes.
    task op(input [3:0] c, input [7:0] d, input [7:0] r, input [2:0] b, input [2:0] s, input [7:0] iod);
        reg [15:0] e;
        begin
            e = expect_of(c, d, r, b, s, es);
            op_valid <= 1'b1;
            op_code <= c;
            rd_data <= d;
            rr_data <= r;
            rd_idx <= r[4:0];
            bit_sel <= b;
            flag_sel <= s;
            io_addr <= d[5:0];
            io_rdata <= iod;
            @(posedge core_clk);
            op_valid <= 1'b0;
            if (c < 4'h2) begin
                #1;
                chk(io_rd_en_q, 1'b1);
                chk(io_addr_q, d[5:0]);
                @(posedge core_clk);
                io_rdata <= ~iod;
            end
            #1;
            chk(done_q, 1'b1);
            chk(status_q, e[15:8]);
            if (c < 4'h2) begin
                chk(io_wdata_q, c[0] ? iod & ~(8'h01 << b) : iod | (8'h01 << b));
                chk(io_wr_en_q, 1'b1);
                chk(busy_q, 1'b0);
            end else if (c < 4'h8 || c == `BSX_OP_BLD) begin
                chk(rd_wr_en_q, 1'b1);
                chk(rd_idx_q, r[4:0]);
                chk(rd_wdata_q, e[7:0]);
            end
            es = e[15:8];
            @(posedge core_clk);
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Every code once with carry-edge operands, then a long random mix.
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (k = 0; k < 16; k = k + 1)
            op(k[3:0], 8'h81 ^ k[7:0], 8'hC3, k[2:0], k[2:0], 8'h5A);
        $display("directed test done");
        for (k = 0; k < 400; k = k + 1) begin
            seed = xs(seed);
            op(seed[3:0], seed[11:4], seed[19:12], seed[22:20], seed[25:23], seed[31:24]);
        end
        $display("random test done");
        results;
    end
endmodule
`default_nettype wire
